// File: hw/duart_map.svh
// Register locations, field positions and reset values for the channel register decode
`ifndef DUART_MAP_SVH
`define DUART_MAP_SVH
`define DUART_LOC_DATA 3'h0
`define DUART_LOC_IER 3'h1
`define DUART_LOC_ISR 3'h2
`define DUART_LOC_LCR 3'h3
`define DUART_LOC_MCR 3'h4
`define DUART_LOC_LSR 3'h5
`define DUART_LOC_MSR 3'h6
`define DUART_LOC_SPR 3'h7
`define DUART_DIV_EN_BIT 7
`define DUART_IER_MSB 3
`define DUART_MCR_MSB 4
`define DUART_RST_DIV 16'h0000
`define DUART_RST_IER 4'h0
`define DUART_RST_LCR 8'h00
`define DUART_RST_MCR 5'h00
`define DUART_RST_SPR 8'h00
`define DUART_RST_TX 8'h00
`define DUART_RST_FCR 8'h00
`define DUART_READ_ZERO 8'h00
`define DUART_SYNC_W 15
`define DUART_SYNC_RST 15'h0f00
`endif

// File: hw/duart_pkg.sv
// Types shared by the channel register decode
package duart_pkg;
  typedef enum logic [3:0] {
    SL_RX = 4'h0, SL_TX = 4'h1, SL_DLO = 4'h2, SL_DHI = 4'h3,
    SL_IER = 4'h4, SL_ISR = 4'h5, SL_FCR = 4'h6, SL_LCR = 4'h7,
    SL_MCR = 4'h8, SL_LSR = 4'h9, SL_MSR = 4'ha, SL_SPR = 4'hb,
    SL_NONE = 4'hf
  } duart_slot_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0, BUS_RD = 2'h1, BUS_WR = 2'h2
  } duart_bus_st_t;
  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0] interrupt_enable;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] scratch_pad;
    logic [7:0] tx;
    logic tx_load;
    logic [7:0] fifo_control;
    logic fcr_load;
  } duart_ctrl_t;
  typedef struct packed {
    logic [7:0] rx;
    logic [7:0] interrupt_status;
    logic [7:0] line_status;
    logic [7:0] modem_status;
  } duart_stat_t;
  typedef struct packed {
    logic rx_read;
    logic isr_read;
    logic lsr_read;
    logic msr_read;
  } duart_evt_t;
  typedef struct packed {
    logic chan;
    logic [2:0] addr;
    logic [7:0] wdata;
  } duart_acc_t;
endpackage

// File: hw/duart_sync.sv
// Two-stage synchroniser for the host bus pins
`timescale 1ns/10ps
`default_nettype none
module duart_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // duart_sync
`default_nettype wire

// File: hw/duart_chan_store.sv
// Register storage of one serial channel
`timescale 1ns/10ps
`default_nettype none
`include "duart_map.svh"
module duart_chan_store (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire duart_pkg::duart_slot_t slot,
  input wire logic [7:0] wdata,
  output var duart_pkg::duart_ctrl_t ctrl
);
  logic [15:0] div_q;
  logic [`DUART_IER_MSB:0] ier_q;
  logic [7:0] lcr_q;
  logic [`DUART_MCR_MSB:0] mcr_q;
  logic [7:0] spr_q;
  logic [7:0] tx_q;
  logic tx_ld_q;
  logic [7:0] fcr_q;
  logic fcr_ld_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= `DUART_RST_DIV;
    end else if (wr_en && slot == duart_pkg::SL_DLO) begin
      div_q[7:0] <= wdata;
    end else if (wr_en && slot == duart_pkg::SL_DHI) begin
      div_q[15:8] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ier_q <= `DUART_RST_IER;
    end else if (wr_en && slot == duart_pkg::SL_IER) begin
      ier_q <= wdata[`DUART_IER_MSB:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lcr_q <= `DUART_RST_LCR;
    end else if (wr_en && slot == duart_pkg::SL_LCR) begin
      lcr_q <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mcr_q <= `DUART_RST_MCR;
    end else if (wr_en && slot == duart_pkg::SL_MCR) begin
      mcr_q <= wdata[`DUART_MCR_MSB:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spr_q <= `DUART_RST_SPR;
    end else if (wr_en && slot == duart_pkg::SL_SPR) begin
      spr_q <= wdata;
    end
  end

  // Transmit byte and fifo control carry a one-cycle load pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_q <= `DUART_RST_TX;
      tx_ld_q <= 1'b0;
    end else begin
      tx_ld_q <= wr_en && slot == duart_pkg::SL_TX;
      if (wr_en && slot == duart_pkg::SL_TX) begin
        tx_q <= wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fcr_q <= `DUART_RST_FCR;
      fcr_ld_q <= 1'b0;
    end else begin
      fcr_ld_q <= wr_en && slot == duart_pkg::SL_FCR;
      if (wr_en && slot == duart_pkg::SL_FCR) begin
        fcr_q <= wdata;
      end
    end
  end

  always_comb begin
    ctrl = '0;
    ctrl.divisor = div_q;
    ctrl.interrupt_enable = {4'h0, ier_q};
    ctrl.line_control = lcr_q;
    ctrl.modem_control = {3'h0, mcr_q};
    ctrl.scratch_pad = spr_q;
    ctrl.tx = tx_q;
    ctrl.tx_load = tx_ld_q;
    ctrl.fifo_control = fcr_q;
    ctrl.fcr_load = fcr_ld_q;
  end
endmodule // duart_chan_store
`default_nettype wire

// File: hw/duart_dec.sv
// Host bus decode for the two serial channel register sets
`timescale 1ns/10ps
`default_nettype none
`include "duart_map.svh"
module duart_dec (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic channel_a_select_n,
  input wire logic channel_b_select_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire duart_pkg::duart_stat_t stat_a,
  input wire duart_pkg::duart_stat_t stat_b,
  output var duart_pkg::duart_ctrl_t ctrl_a,
  output var duart_pkg::duart_ctrl_t ctrl_b,
  output var duart_pkg::duart_evt_t evt_a,
  output var duart_pkg::duart_evt_t evt_b
);
  logic [`DUART_SYNC_W-1:0] raw_w;
  logic [`DUART_SYNC_W-1:0] sync_w;
  logic [2:0] s_addr;
  logic s_csb_n;
  logic s_csa_n;
  logic s_rd_n;
  logic s_wr_n;
  logic [7:0] s_data;
  logic s_hit;
  logic s_chan;
  duart_pkg::duart_bus_st_t st_q;
  duart_pkg::duart_bus_st_t st_d;
  duart_pkg::duart_acc_t acc_q;
  logic [7:0] rdata_q;
  logic oe_n_q;
  logic wr_commit;
  logic rd_done;
  duart_pkg::duart_slot_t rd_slot_w;
  duart_pkg::duart_slot_t wr_slot_w;
  duart_pkg::duart_slot_t ev_slot_w;
  duart_pkg::duart_ctrl_t ctrl_w [2];
  duart_pkg::duart_stat_t stat_w [2];
  duart_pkg::duart_evt_t evt_q [2];
  logic div_en_w [2];

  // Location to register slot, steered by the divisor enable bit
  function automatic duart_pkg::duart_slot_t slot_of(
    input logic [2:0] loc,
    input logic div_en,
    input logic is_wr
  );
    duart_pkg::duart_slot_t s;
    s = duart_pkg::SL_NONE;
    case (loc)
      `DUART_LOC_DATA: begin
        if (div_en) begin
          s = duart_pkg::SL_DLO;
        end else begin
          s = is_wr ? duart_pkg::SL_TX : duart_pkg::SL_RX;
        end
      end
      `DUART_LOC_IER: begin
        s = div_en ? duart_pkg::SL_DHI : duart_pkg::SL_IER;
      end
      `DUART_LOC_ISR: begin
        s = is_wr ? duart_pkg::SL_FCR : duart_pkg::SL_ISR;
      end
      `DUART_LOC_LCR: begin
        s = duart_pkg::SL_LCR;
      end
      `DUART_LOC_MCR: begin
        s = duart_pkg::SL_MCR;
      end
      `DUART_LOC_LSR: begin
        s = is_wr ? duart_pkg::SL_NONE : duart_pkg::SL_LSR;
      end
      `DUART_LOC_MSR: begin
        s = is_wr ? duart_pkg::SL_NONE : duart_pkg::SL_MSR;
      end
      `DUART_LOC_SPR: begin
        s = duart_pkg::SL_SPR;
      end
      default: begin
        s = duart_pkg::SL_NONE;
      end
    endcase
    return s;
  endfunction

  function automatic logic [7:0] read_val(
    input duart_pkg::duart_slot_t s,
    input duart_pkg::duart_ctrl_t c,
    input duart_pkg::duart_stat_t t
  );
    logic [7:0] v;
    v = `DUART_READ_ZERO;
    case (s)
      duart_pkg::SL_RX: v = t.rx;
      duart_pkg::SL_DLO: v = c.divisor[7:0];
      duart_pkg::SL_DHI: v = c.divisor[15:8];
      duart_pkg::SL_IER: v = c.interrupt_enable;
      duart_pkg::SL_ISR: v = t.interrupt_status;
      duart_pkg::SL_LCR: v = c.line_control;
      duart_pkg::SL_MCR: v = c.modem_control;
      duart_pkg::SL_LSR: v = t.line_status;
      duart_pkg::SL_MSR: v = t.modem_status;
      duart_pkg::SL_SPR: v = c.scratch_pad;
      default: v = `DUART_READ_ZERO;
    endcase
    return v;
  endfunction

  // All host pins cross into the clock domain together
  assign raw_w = {addr, channel_b_select_n, channel_a_select_n, read_n, write_n, data_in};

  duart_sync #(
    .WIDTH(`DUART_SYNC_W),
    .RST_VAL(`DUART_SYNC_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din(raw_w),
    .dout(sync_w)
  );

  assign s_addr = sync_w[14:12];
  assign s_csb_n = sync_w[11];
  assign s_csa_n = sync_w[10];
  assign s_rd_n = sync_w[9];
  assign s_wr_n = sync_w[8];
  assign s_data = sync_w[7:0];
  // Exactly one select low; both low is no access
  assign s_hit = s_csa_n ^ s_csb_n;
  assign s_chan = s_csa_n;

  assign stat_w[0] = stat_a;
  assign stat_w[1] = stat_b;
  assign ctrl_a = ctrl_w[0];
  assign ctrl_b = ctrl_w[1];
  assign evt_a = evt_q[0];
  assign evt_b = evt_q[1];

  always_comb begin
    st_d = st_q;
    case (st_q)
      duart_pkg::BUS_IDLE: begin
        if (s_hit && !s_rd_n && s_wr_n) begin
          st_d = duart_pkg::BUS_RD;
        end else if (s_hit && !s_wr_n && s_rd_n) begin
          st_d = duart_pkg::BUS_WR;
        end
      end
      duart_pkg::BUS_RD: begin
        if (s_rd_n) begin
          st_d = duart_pkg::BUS_IDLE;
        end
      end
      duart_pkg::BUS_WR: begin
        if (s_wr_n) begin
          st_d = duart_pkg::BUS_IDLE;
        end
      end
      default: begin
        st_d = duart_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= duart_pkg::BUS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Access captured while the strobe is low, used at release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
    end else if (st_d != duart_pkg::BUS_IDLE && s_hit && !(s_rd_n && s_wr_n)) begin
      acc_q.chan <= s_chan;
      acc_q.addr <= s_addr;
      acc_q.wdata <= s_data;
    end
  end

  generate
    for (genvar g = 0; g < 2; g++) begin : g_div
      assign div_en_w[g] = ctrl_w[g].line_control[`DUART_DIV_EN_BIT];
    end
  endgenerate

  assign rd_slot_w = slot_of(s_addr, div_en_w[s_chan], 1'b0);
  assign wr_slot_w = slot_of(acc_q.addr, div_en_w[acc_q.chan], 1'b1);
  assign ev_slot_w = slot_of(acc_q.addr, div_en_w[acc_q.chan], 1'b0);
  assign wr_commit = st_q == duart_pkg::BUS_WR && s_wr_n;
  assign rd_done = st_q == duart_pkg::BUS_RD && s_rd_n;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `DUART_READ_ZERO;
    end else if (st_d == duart_pkg::BUS_RD && s_hit) begin
      rdata_q <= read_val(rd_slot_w, ctrl_w[s_chan], stat_w[s_chan]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= st_d != duart_pkg::BUS_RD;
    end
  end

  assign data_out = rdata_q;
  assign data_oe_n = oe_n_q;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_chan
      logic sel_w;
      assign sel_w = acc_q.chan == 1'(g);

      duart_chan_store u_store (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_commit && sel_w),
        .slot(wr_slot_w),
        .wdata(acc_q.wdata),
        .ctrl(ctrl_w[g])
      );

      // Read side effects go to the rest of the channel
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          evt_q[g] <= '0;
        end else begin
          evt_q[g].rx_read <= rd_done && sel_w && ev_slot_w == duart_pkg::SL_RX;
          evt_q[g].isr_read <= rd_done && sel_w && ev_slot_w == duart_pkg::SL_ISR;
          evt_q[g].lsr_read <= rd_done && sel_w && ev_slot_w == duart_pkg::SL_LSR;
          evt_q[g].msr_read <= rd_done && sel_w && ev_slot_w == duart_pkg::SL_MSR;
        end
      end
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence wr_at_s(logic [2:0] loc);
    st_q == duart_pkg::BUS_WR && s_wr_n && !acc_q.chan && acc_q.addr == loc;
  endsequence

  sequence rd_at_s(logic [2:0] loc);
    st_q == duart_pkg::BUS_RD && !acc_q.chan && acc_q.addr == loc;
  endsequence

  sequence rd_end_s(logic [2:0] loc);
    rd_at_s(loc) ##0 s_rd_n;
  endsequence

  chan_b_iso_a: assert property (
    wr_commit && acc_q.chan |=> $stable(ctrl_w[0].line_control) && $stable(ctrl_w[0].scratch_pad))
    else $error("write to channel b changed channel a");

  rd_drive_a: assert property (
    st_q == duart_pkg::BUS_IDLE && st_d == duart_pkg::BUS_RD |=> !data_oe_n [*1] ##1 1'b1)
    else $error("data bus not driven during read");

  tx_load_a: assert property (
    wr_at_s(`DUART_LOC_DATA) ##0 !div_en_w[0] |=>
      ctrl_w[0].tx_load && ctrl_w[0].tx == $past(acc_q.wdata) && $stable(ctrl_w[0].divisor))
    else $error("transmit byte not loaded");

  rx_read_a: assert property (
    rd_at_s(`DUART_LOC_DATA) ##0 !div_en_w[0] |-> rdata_q == $past(stat_a.rx))
    else $error("receive byte not returned");

  rx_evt_a: assert property (
    rd_end_s(`DUART_LOC_DATA) ##0 !div_en_w[0] |=> evt_a.rx_read ##1 !evt_a.rx_read)
    else $error("receive read pulse wrong");

  div_low_a: assert property (
    wr_at_s(`DUART_LOC_DATA) ##0 div_en_w[0] |=>
      ctrl_w[0].divisor[7:0] == $past(acc_q.wdata) && !ctrl_w[0].tx_load)
    else $error("divisor low byte not written");

  div_low_rd_a: assert property (
    rd_at_s(`DUART_LOC_DATA) ##0 div_en_w[0] |-> rdata_q == ctrl_w[0].divisor[7:0])
    else $error("divisor low byte not returned");

  div_high_a: assert property (
    wr_at_s(`DUART_LOC_IER) ##0 div_en_w[0] |=>
      ctrl_w[0].divisor[15:8] == $past(acc_q.wdata) && $stable(ctrl_w[0].interrupt_enable))
    else $error("divisor high byte not written");

  ier_write_a: assert property (
    wr_at_s(`DUART_LOC_IER) ##0 !div_en_w[0] |=>
      ctrl_w[0].interrupt_enable == {4'h0, $past(acc_q.wdata[3:0])} && $stable(ctrl_w[0].divisor))
    else $error("interrupt enable not written");

  fcr_load_a: assert property (
    wr_at_s(`DUART_LOC_ISR) |=> ctrl_w[0].fcr_load && ctrl_w[0].fifo_control == $past(acc_q.wdata))
    else $error("fifo control not loaded");

  isr_read_a: assert property (
    rd_at_s(`DUART_LOC_ISR) |-> rdata_q == $past(stat_a.interrupt_status))
    else $error("interrupt status not returned");

  lcr_write_a: assert property (
    wr_at_s(`DUART_LOC_LCR) |=> ctrl_w[0].line_control == $past(acc_q.wdata))
    else $error("line control not written");

  mcr_write_a: assert property (
    wr_at_s(`DUART_LOC_MCR) |=> ctrl_w[0].modem_control == {3'h0, $past(acc_q.wdata[4:0])})
    else $error("modem control not written");

  lsr_ro_a: assert property (
    wr_at_s(`DUART_LOC_LSR) |=> $stable(ctrl_w[0].divisor) && $stable(ctrl_w[0].interrupt_enable) &&
      $stable(ctrl_w[0].line_control) && $stable(ctrl_w[0].modem_control) && $stable(ctrl_w[0].scratch_pad) &&
      !ctrl_w[0].tx_load && !ctrl_w[0].fcr_load)
    else $error("write to line status location had an effect");

  msr_ro_a: assert property (
    wr_at_s(`DUART_LOC_MSR) |=> $stable(ctrl_w[0].line_control) && $stable(ctrl_w[0].scratch_pad) &&
      !ctrl_w[0].tx_load && !ctrl_w[0].fcr_load)
    else $error("write to modem status location had an effect");

  msr_evt_a: assert property (
    rd_end_s(`DUART_LOC_MSR) |=> evt_a.msr_read && !evt_a.lsr_read)
    else $error("modem status read pulse missing");

  spr_rt_a: assert property (
    wr_at_s(`DUART_LOC_SPR) |=> ctrl_w[0].scratch_pad == $past(acc_q.wdata) &&
      !ctrl_w[0].tx_load && !ctrl_w[0].fcr_load)
    else $error("scratch byte not stored");
endmodule // duart_dec
`default_nettype wire

// File: bench/duart_host_model.sv
// Host processor model driving the channel register bus pins
`timescale 1ns/10ps
`default_nettype none
module duart_host_model (
  input wire logic clk,
  output logic [2:0] addr,
  output logic channel_a_select_n,
  output logic channel_b_select_n,
  output logic read_n,
  output logic write_n,
  output logic [7:0] data_in
);
  initial begin
    addr = 3'h0;
    channel_a_select_n = 1'b1;
    channel_b_select_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    data_in = 8'h00;
  end

  // One access; sel_n is {b, a}, pins held while the strobe is low
  task automatic access(input logic is_wr, input logic [1:0] sel_n, input logic [2:0] loc,
                        input logic [7:0] d);
    @(posedge clk);
    addr <= loc;
    {channel_b_select_n, channel_a_select_n} <= sel_n;
    data_in <= is_wr ? d : ~data_in;
    if (is_wr) begin
      write_n <= 1'b0;
    end else begin
      read_n <= 1'b0;
    end
    repeat (5) @(posedge clk);
    read_n <= 1'b1;
    write_n <= 1'b1;
    @(posedge clk);
    // Released lines show no stale value
    {channel_b_select_n, channel_a_select_n} <= 2'b11;
    addr <= ~loc;
    data_in <= ~data_in;
    repeat (4) @(posedge clk);
  endtask
endmodule // duart_host_model
`default_nettype wire

// File: bench/dual_uart_register_decode_tb.sv
// Self-checking bench for the channel register decode
`timescale 1ns/10ps
`default_nettype none
module dual_uart_register_decode_tb;
  logic clk;
  logic rst;
  logic [2:0] addr;
  logic sel_a_n;
  logic sel_b_n;
  logic read_n;
  logic write_n;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic data_oe_n;
  duart_pkg::duart_stat_t st_a;
  duart_pkg::duart_stat_t st_b;
  duart_pkg::duart_ctrl_t ctrl_a;
  duart_pkg::duart_ctrl_t ctrl_b;
  duart_pkg::duart_evt_t evt_a;
  duart_pkg::duart_evt_t evt_b;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] rd_q[$];
  logic [9:0] ld_q[$];
  logic [4:0] ev_q[$];
  logic [7:0] m_line[2], m_dlo[2], m_dhi[2], m_ien[2], m_modem[2], m_pad[2];
  logic oe_prev = 1'b1;
  int unsigned seed_val;

  duart_dec duart_dec_inst (.clk(clk), .rst(rst), .addr(addr), .channel_a_select_n(sel_a_n),
    .channel_b_select_n(sel_b_n), .read_n(read_n), .write_n(write_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .stat_a(st_a), .stat_b(st_b),
    .ctrl_a(ctrl_a), .ctrl_b(ctrl_b), .evt_a(evt_a), .evt_b(evt_b));
  duart_host_model duart_host_model_inst (.clk(clk), .addr(addr), .channel_a_select_n(sel_a_n),
    .channel_b_select_n(sel_b_n), .read_n(read_n), .write_n(write_n), .data_in(data_in));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [7:0] exp_rd(input int c, input logic [2:0] loc);
    duart_pkg::duart_stat_t s;
    s = (c == 1) ? st_b : st_a;
    case (loc)
      3'h0: return m_line[c][7] ? m_dlo[c] : s.rx;
      3'h1: return m_line[c][7] ? m_dhi[c] : m_ien[c];
      3'h2: return s.interrupt_status;
      3'h3: return m_line[c];
      3'h4: return m_modem[c];
      3'h5: return s.line_status;
      3'h6: return s.modem_status;
      default: return m_pad[c];
    endcase
  endfunction

  // Notes the expectation, then runs the access on channel c
  task automatic do_acc(input int c, input logic wr, input logic [2:0] loc, input logic [7:0] d);
    logic [3:0] e;
    e = 4'h0;
    if (!wr) begin
      rd_q.push_back(exp_rd(c, loc));
      // Read side-effect pulse expected at strobe release
      case (loc)
        3'h0: e = m_line[c][7] ? 4'h0 : 4'h8;
        3'h2: e = 4'h4;
        3'h5: e = 4'h2;
        3'h6: e = 4'h1;
        default: e = 4'h0;
      endcase
      if (e != 4'h0) ev_q.push_back({c[0], e});
    end else begin
      case (loc)
        3'h0: if (m_line[c][7]) m_dlo[c] = d; else ld_q.push_back({c[0], 1'b0, d});
        3'h1: if (m_line[c][7]) m_dhi[c] = d; else m_ien[c] = {4'h0, d[3:0]};
        3'h2: ld_q.push_back({c[0], 1'b1, d});
        3'h3: m_line[c] = d;
        3'h4: m_modem[c] = {3'h0, d[4:0]};
        3'h7: m_pad[c] = d;
        default: ;
      endcase
    end
    duart_host_model_inst.access(wr, (c == 1) ? 2'b01 : 2'b10, loc, d);
  endtask

  task automatic pop_ld(input logic [9:0] seen);
    if (ld_q.size() == 0) begin
      check("unexpected load", {6'h0, seen}, 16'hffff);
    end else begin
      check("load pulse", {6'h0, seen}, {6'h0, ld_q.pop_front()});
    end
  endtask

  task automatic pop_ev(input logic [4:0] seen);
    if (ev_q.size() == 0) begin
      check("unexpected read pulse", {11'h0, seen}, 16'hffff);
    end else begin
      check("read pulse", {11'h0, seen}, {11'h0, ev_q.pop_front()});
    end
  endtask

  always @(negedge clk) begin
    if (!rst) begin
      if (data_oe_n === 1'b0 && oe_prev) begin
        if (rd_q.size() == 0) begin
          check("unexpected read", {8'h0, data_out}, 16'hffff);
        end else begin
          check("read data", {8'h0, data_out}, {8'h0, rd_q.pop_front()});
        end
      end
      oe_prev = (data_oe_n !== 1'b0);
      if (ctrl_a.tx_load === 1'b1) pop_ld({1'b0, 1'b0, ctrl_a.tx});
      if (ctrl_a.fcr_load === 1'b1) pop_ld({1'b0, 1'b1, ctrl_a.fifo_control});
      if (ctrl_b.tx_load === 1'b1) pop_ld({1'b1, 1'b0, ctrl_b.tx});
      if (ctrl_b.fcr_load === 1'b1) pop_ld({1'b1, 1'b1, ctrl_b.fifo_control});
      if (4'(evt_a) !== 4'h0) pop_ev({1'b0, 4'(evt_a)});
      if (4'(evt_b) !== 4'h0) pop_ev({1'b1, 4'(evt_b)});
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    int c;
    int k;
    rst = 1'b1;
    st_a = '0;
    st_b = '0;
    for (c = 0; c < 2; c++) begin
      {m_line[c], m_dlo[c], m_dhi[c], m_ien[c], m_modem[c], m_pad[c]} = '0;
    end
    seed_val = $urandom(32'hb14c9397);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    st_a <= duart_pkg::duart_stat_t'($urandom);
    st_b <= duart_pkg::duart_stat_t'($urandom);
    @(posedge clk);
    check("div reset", ctrl_a.divisor | ctrl_b.divisor, 16'h0000);
    for (k = 0; k < 16; k++) do_acc(k / 8, 1'b0, k[2:0], 8'h00);
    // Both selects low: no channel may take it
    duart_host_model_inst.access(1'b1, 2'b00, 3'h7, 8'h5a);
    for (c = 0; c < 2; c++) begin
      do_acc(c, 1'b1, 3'h5, 8'hff);
      do_acc(c, 1'b1, 3'h6, 8'hff);
      do_acc(c, 1'b0, 3'h7, 8'h00);
      do_acc(c, 1'b1, 3'h3, 8'h83);
      do_acc(c, 1'b1, 3'h0, 8'($urandom));
      do_acc(c, 1'b1, 3'h1, 8'($urandom));
      for (k = 0; k < 8; k++) do_acc(c, 1'b0, k[2:0], 8'h00);
      do_acc(c, 1'b1, 3'h3, 8'h03);
    end
    for (k = 0; k < 120; k++) begin
      @(posedge clk);
      st_a <= duart_pkg::duart_stat_t'($urandom);
      st_b <= duart_pkg::duart_stat_t'($urandom);
      @(posedge clk);
      do_acc(int'($urandom % 2), 1'($urandom), 3'($urandom), 8'($urandom));
    end
    for (k = 0; k < 50 && (rd_q.size() + ld_q.size() + ev_q.size()) != 0; k++) @(posedge clk);
    if ((rd_q.size() + ld_q.size() + ev_q.size()) != 0) err_total++;
    check("div a", ctrl_a.divisor, {m_dhi[0], m_dlo[0]});
    check("div b", ctrl_b.divisor, {m_dhi[1], m_dlo[1]});
    check("ier a", {8'h0, ctrl_a.interrupt_enable}, {8'h0, m_ien[0]});
    check("mcr b", {8'h0, ctrl_b.modem_control}, {8'h0, m_modem[1]});
    check("spr a", {ctrl_a.scratch_pad, ctrl_a.line_control}, {m_pad[0], m_line[0]});
    close_out();
  end
endmodule // dual_uart_register_decode_tb
`default_nettype wire
